// ==== vsq_ctrl_event.v ====
// control queue interpreter and event record builder
`timescale 1ns/10ps
`default_nettype none
`include "vsq_consts.vh"
module vsq_ctrl_event #(
  parameter LUNS_W = 4,
  parameter SUPPORTED = 32'h0000007E
) (
  input  wire        clk,
  input  wire        rst_n,
  input  wire        legacy_be,
  input  wire        hotplug_ok,
  input  wire        ctl_valid,
  input  wire [31:0] ctl_type,
  input  wire [31:0] ctl_subtype,
  input  wire [63:0] ctl_lun,
  input  wire [63:0] ctl_id,
  input  wire [31:0] ctl_evt_req,
  output reg         ctl_busy,
  output reg         ctl_done,
  output reg  [7:0]  ctl_resp,
  output reg  [31:0] ctl_evt_act,
  output reg         kill_valid,
  output reg  [1:0]  kill_scope,
  output reg  [63:0] kill_lun,
  output reg  [63:0] kill_id,
  output reg  [7:0]  kill_resp,
  input  wire        kill_done,
  input  wire        kill_found,
  input  wire        evq_buf_avail,
  input  wire        evq_buf_short,
  output reg         evq_take,
  output reg         evq_write,
  output reg  [31:0] evq_event,
  output reg  [63:0] evq_lun,
  output reg  [31:0] evq_reason,
  input  wire        lu_evt_valid,
  input  wire [1:0]  lu_evt_why,
  input  wire [63:0] lu_evt_lun,
  input  wire        an_evt_valid,
  input  wire [31:0] an_evt_mask,
  input  wire [63:0] an_evt_lun,
  output reg         sense_valid,
  output reg  [3:0]  sense_key,
  output reg  [7:0]  sense_asc,
  output reg  [7:0]  sense_ascq,
  output reg  [63:0] sense_lun
);
  localparam ST_IDLE = 2'd0;
  localparam ST_KILL = 2'd1;
  localparam ST_WAIT = 2'd2;
  localparam NLUN = 1 << LUNS_W;

  reg [1:0]  state;
  reg [31:0] sub_mask [0:NLUN-1];
  reg        missed;
  reg [31:0] t_type;
  reg [31:0] t_sub;
  reg [63:0] t_id;
  integer    i;

  // byte swap used in legacy mode for type, subtype, id, event mask, event and reason fields; lun fields are not swapped
  function [31:0] sw32;
    input [31:0] v;
    input        en;
    begin
      sw32 = en ? {v[7:0], v[15:8], v[23:16], v[31:24]} : v;
    end
  endfunction

  function [63:0] sw64;
    input [63:0] v;
    input        en;
    begin
      sw64 = en ? {sw32(v[31:0], 1'b1), sw32(v[63:32], 1'b1)} : v;
    end
  endfunction

  // lun byte 2/3 hold the single level lun; low bits index the table
  function [LUNS_W-1:0] lun_idx;
    input [63:0] l;
    begin
      lun_idx = l[16+LUNS_W-1:16];
    end
  endfunction

  // guest order on incoming multibyte fields
  wire [31:0] in_type = sw32(ctl_type, legacy_be);
  wire [31:0] in_sub  = sw32(ctl_subtype, legacy_be);
  wire [31:0] in_req  = sw32(ctl_evt_req, legacy_be);
  wire [63:0] in_id   = sw64(ctl_id, legacy_be);
  wire [31:0] granted = in_req & SUPPORTED & `VSQ_AN_CLASSES;

  always @(posedge clk) begin
    if (!rst_n) begin
      state       <= ST_IDLE;
      ctl_busy    <= 1'b0;
      ctl_done    <= 1'b0;
      ctl_resp    <= 8'h00;
      ctl_evt_act <= 32'h00000000;
      kill_valid  <= 1'b0;
      kill_scope  <= 2'd0;
      kill_lun    <= 64'h0000000000000000;
      kill_id     <= 64'h0000000000000000;
      kill_resp   <= 8'h00;
      t_type      <= 32'h00000000;
      t_sub       <= 32'h00000000;
      t_id        <= 64'h0000000000000000;
      for (i = 0; i < NLUN; i = i + 1)
        sub_mask[i] <= 32'h00000000;
    end else begin
      ctl_done <= 1'b0;
      case (state)
        ST_IDLE: begin
          if (ctl_valid) begin
            t_type <= in_type;
            t_sub  <= in_sub;
            t_id   <= in_id;
            ctl_busy <= 1'b1;
            if (in_type == `VSQ_TYPE_AN_QUERY) begin
              ctl_evt_act <= sw32(granted, legacy_be);
              ctl_resp    <= (ctl_lun[7:0] == `VSQ_LUN_FMT_TARGET) ?
                             `VSQ_RESP_OK : `VSQ_RESP_BAD_LUN;
              ctl_done    <= 1'b1;
              ctl_busy    <= 1'b0;
            end else if (in_type == `VSQ_TYPE_AN_SUB) begin
              if (ctl_lun[7:0] == `VSQ_LUN_FMT_TARGET) begin
                sub_mask[lun_idx(ctl_lun)] <= granted;
                ctl_resp <= `VSQ_RESP_OK;
              end else begin
                ctl_resp <= `VSQ_RESP_BAD_LUN;
              end
              ctl_evt_act <= sw32(granted, legacy_be);
              ctl_done    <= 1'b1;
              ctl_busy    <= 1'b0;
            end else if (in_type == `VSQ_TYPE_TMF) begin
              // type picks tmf, subtype picks function
              ctl_evt_act <= 32'h00000000;
              kill_lun    <= ctl_lun;
              // nexus reset ignores the single level lun
              if (in_sub == `VSQ_TMF_IT_RESET)
                kill_lun[31:16] <= 16'h0000;
              kill_id <= in_id;
              case (in_sub)
                `VSQ_TMF_ABORT_TASK: begin
                  kill_scope <= 2'd0;
                  kill_resp  <= `VSQ_RESP_ABORTED;
                  kill_valid <= 1'b1;
                  state      <= ST_KILL;
                end
                `VSQ_TMF_ABORT_SET, `VSQ_TMF_CLEAR_SET: begin
                  kill_scope <= 2'd1;
                  kill_resp  <= `VSQ_RESP_ABORTED;
                  kill_valid <= 1'b1;
                  state      <= ST_KILL;
                end
                `VSQ_TMF_LU_RESET: begin
                  kill_scope <= 2'd1;
                  kill_resp  <= `VSQ_RESP_RESET;
                  kill_valid <= 1'b1;
                  state      <= ST_KILL;
                end
                `VSQ_TMF_IT_RESET: begin
                  kill_scope <= 2'd2;
                  kill_resp  <= `VSQ_RESP_RESET;
                  kill_valid <= 1'b1;
                  state      <= ST_KILL;
                end
                // query functions only look; no command is touched
                `VSQ_TMF_QUERY_TASK, `VSQ_TMF_QUERY_SET: begin
                  kill_scope <= (in_sub == `VSQ_TMF_QUERY_TASK) ? 2'd0 : 2'd1;
                  kill_resp  <= 8'h00;
                  kill_valid <= 1'b1;
                  state      <= ST_KILL;
                end
                `VSQ_TMF_CLEAR_ACA: begin
                  ctl_resp <= `VSQ_FN_COMPLETE;
                  ctl_done <= 1'b1;
                  ctl_busy <= 1'b0;
                end
                default: begin
                  ctl_resp <= `VSQ_RESP_FAILURE;
                  ctl_done <= 1'b1;
                  ctl_busy <= 1'b0;
                end
              endcase
            end else begin
              ctl_resp <= `VSQ_RESP_FAILURE;
              ctl_done <= 1'b1;
              ctl_busy <= 1'b0;
            end
          end
        end
        ST_KILL: begin
          // answer only after completions are written
          if (kill_done) begin
            kill_valid <= 1'b0;
            state      <= ST_WAIT;
            if ((t_sub == `VSQ_TMF_QUERY_TASK) || (t_sub == `VSQ_TMF_QUERY_SET))
              ctl_resp <= kill_found ? `VSQ_FN_SUCCEEDED : `VSQ_FN_COMPLETE;
            else
              ctl_resp <= `VSQ_FN_COMPLETE;
          end
        end
        ST_WAIT: begin
          // one spare cycle keeps completion writes ahead of the answer
          ctl_done <= 1'b1;
          ctl_busy <= 1'b0;
          state    <= ST_IDLE;
        end
        default: state <= ST_IDLE;
      endcase
    end
  end

  // event side: lu events win over async events in the same cycle
  wire        evt_removal = (lu_evt_why != 2'd0);
  wire        lu_ok   = lu_evt_valid && (!evt_removal || hotplug_ok) &&
                        (lu_evt_why != 2'd3);
  wire [31:0] an_kept = an_evt_mask & sub_mask[lun_idx(an_evt_lun)];
  wire        an_ok   = an_evt_valid && (an_kept != 32'h00000000);
  wire        want    = lu_ok || an_ok;

  always @(posedge clk) begin
    if (!rst_n) begin
      missed      <= 1'b0;
      evq_take    <= 1'b0;
      evq_write   <= 1'b0;
      evq_event   <= 32'h00000000;
      evq_lun     <= 64'h0000000000000000;
      evq_reason  <= 32'h00000000;
      sense_valid <= 1'b0;
      sense_key   <= 4'h0;
      sense_asc   <= 8'h00;
      sense_ascq  <= 8'h00;
      sense_lun   <= 64'h0000000000000000;
    end else begin
      evq_take    <= 1'b0;
      evq_write   <= 1'b0;
      sense_valid <= 1'b0;
      if (lu_ok) begin
        sense_valid <= 1'b1;
        sense_lun   <= lu_evt_lun;
        case (lu_evt_why)
          2'd2: begin
            sense_key  <= `VSQ_KEY_ILLEGAL;
            sense_asc  <= `VSQ_ASC_REMOVED;
            sense_ascq <= `VSQ_ASCQ_ZERO;
          end
          2'd1: begin
            sense_key  <= `VSQ_KEY_UNIT_ATTN;
            sense_asc  <= `VSQ_ASC_RESCAN;
            sense_ascq <= `VSQ_ASCQ_RESCAN;
          end
          default: begin
            sense_key  <= `VSQ_KEY_UNIT_ATTN;
            sense_asc  <= `VSQ_ASC_HARD;
            sense_ascq <= `VSQ_ASCQ_ZERO;
          end
        endcase
      end
      if (evq_buf_avail && !evq_take) begin
        if (evq_buf_short) begin
          // short buffer goes back with no event
          evq_take   <= 1'b1;
          evq_write  <= 1'b1;
          evq_event  <= sw32(`VSQ_EVT_NONE, legacy_be);
          evq_lun    <= 64'h0000000000000000;
          evq_reason <= 32'h00000000;
          if (want)
            missed <= 1'b1;
        end else if (want || missed) begin
          evq_take  <= 1'b1;
          evq_write <= 1'b1;
          missed    <= 1'b0;
          if (lu_ok) begin
            evq_event  <= sw32({missed, 31'd0} | `VSQ_EVT_RESET, legacy_be);
            evq_lun    <= lu_evt_lun;
            evq_reason <= sw32({30'd0, lu_evt_why}, legacy_be);
            if (an_ok)
              missed <= 1'b1;
          end else if (an_ok) begin
            evq_event  <= sw32({missed, 31'd0} | `VSQ_EVT_ASYNC, legacy_be);
            evq_lun    <= an_evt_lun;
            evq_reason <= sw32(an_kept, legacy_be);
          end else begin
            // report the loss on a fresh buffer
            evq_event  <= sw32({1'b1, 31'd0}, legacy_be);
            evq_lun    <= 64'h0000000000000000;
            evq_reason <= 32'h00000000;
          end
        end
      end else if (want) begin
        missed <= 1'b1;
      end
    end
  end
endmodule // vsq_ctrl_event
`default_nettype wire

// ==== vsq_consts.vh ====
// constants for the control and event queue engine
`ifndef VSQ_CONSTS_VH
`define VSQ_CONSTS_VH
`define VSQ_RESP_OK          8'h00
`define VSQ_RESP_BAD_TARGET  8'h03
`define VSQ_RESP_ABORTED     8'h02
`define VSQ_RESP_RESET       8'h04
`define VSQ_RESP_FAILURE     8'h09
`define VSQ_RESP_BAD_LUN     8'h0C
`define VSQ_FN_COMPLETE      8'h00
`define VSQ_FN_SUCCEEDED     8'h0A
`define VSQ_FN_REJECTED      8'h0B
`define VSQ_TYPE_TMF         32'h00000000
`define VSQ_TYPE_AN_QUERY    32'h00000001
`define VSQ_TYPE_AN_SUB      32'h00000002
`define VSQ_TMF_ABORT_TASK   32'h00000000
`define VSQ_TMF_ABORT_SET    32'h00000001
`define VSQ_TMF_CLEAR_ACA    32'h00000002
`define VSQ_TMF_CLEAR_SET    32'h00000003
`define VSQ_TMF_IT_RESET     32'h00000004
`define VSQ_TMF_LU_RESET     32'h00000005
`define VSQ_TMF_QUERY_TASK   32'h00000006
`define VSQ_TMF_QUERY_SET    32'h00000007
`define VSQ_EVT_NONE         32'h00000000
`define VSQ_EVT_RESET        32'h00000001
`define VSQ_EVT_ASYNC        32'h00000002
`define VSQ_EVT_MISSED_BIT   31
`define VSQ_AN_CLASSES       32'h0000007E
`define VSQ_WHY_HARD         32'h00000000
`define VSQ_WHY_RESCAN       32'h00000001
`define VSQ_WHY_REMOVED      32'h00000002
`define VSQ_KEY_ILLEGAL      4'h5
`define VSQ_KEY_UNIT_ATTN    4'h6
`define VSQ_ASC_REMOVED      8'h25
`define VSQ_ASC_HARD         8'h29
`define VSQ_ASC_RESCAN       8'h3F
`define VSQ_ASCQ_RESCAN      8'h0E
`define VSQ_ASCQ_ZERO        8'h00
`define VSQ_LUN_FMT_TARGET   8'h01
`endif

// ==== vsq_chk_properties.sv ====
// port assertions for the control and event queue engine
`timescale 1ns/10ps
`default_nettype none
`include "vsq_consts.vh"
module vsq_chk (
  input wire logic        clk,
  input wire logic        rst_n,
  input wire logic        legacy_be,
  input wire logic        ctl_valid,
  input wire logic [31:0] ctl_type,
  input wire logic [31:0] ctl_subtype,
  input wire logic [63:0] ctl_lun,
  input wire logic        ctl_busy,
  input wire logic        ctl_done,
  input wire logic        kill_valid,
  input wire logic [7:0]  kill_resp,
  input wire logic        kill_done,
  input wire logic        lu_evt_valid,
  input wire logic [1:0]  lu_evt_why,
  input wire logic        sense_valid,
  input wire logic [3:0]  sense_key,
  input wire logic [7:0]  sense_asc,
  input wire logic        evq_buf_avail,
  input wire logic        evq_take,
  input wire logic        evq_write,
  input wire logic [31:0] evq_event
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  sequence tmf_take;
    ctl_valid && !ctl_busy && !legacy_be && ctl_type == `VSQ_TYPE_TMF && ctl_lun[7:0] == 8'h01;
  endsequence
  sequence kill_end;
    kill_valid && kill_done ##1 !kill_valid;
  endsequence
  chk_query_done: assert property (
    ctl_valid && !ctl_busy && !legacy_be && ctl_type == `VSQ_TYPE_AN_QUERY |=> ctl_done)
    else $error("query not answered next cycle");
  chk_abort_kill: assert property (
    tmf_take ##0 ctl_subtype == `VSQ_TMF_ABORT_SET |=> kill_valid && ctl_busy && kill_resp == 8'h02)
    else $error("abort set without aborted completion request");
  chk_reset_kill: assert property (
    tmf_take ##0 ctl_subtype == `VSQ_TMF_LU_RESET |=> kill_valid && kill_resp == 8'h04)
    else $error("unit reset without reset completion request");
  chk_done_order: assert property (kill_end |=> ctl_done && !ctl_busy)
    else $error("tmf answer not two cycles after completions");
  chk_no_early: assert property (kill_valid |-> !ctl_done)
    else $error("tmf answered while completions pending");
  chk_hard_sense: assert property (
    lu_evt_valid && lu_evt_why == 2'd0 |=> sense_valid && sense_key == 4'h6 && sense_asc == 8'h29)
    else $error("hard reset sense missing");
  chk_buf_needed: assert property (evq_take |-> $past(evq_buf_avail) && evq_write)
    else $error("event written without a buffer");
  chk_code_known: assert property (evq_write && !legacy_be |-> evq_event[30:0] <= 31'd2)
    else $error("unknown event code");
endmodule // vsq_chk
`default_nettype wire

// ==== vsq_guest.sv ====
// guest side model: request queue search and event buffer posting
`timescale 1ns/10ps
`default_nettype none
module vsq_guest #(
  parameter int DLY = 3
) (
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic kill_valid,
  input  wire logic found,
  input  wire logic post,
  input  wire logic short,
  input  wire logic evq_take,
  output var  logic kill_done,
  output wire logic kill_found,
  output wire logic evq_buf_avail,
  output wire logic evq_buf_short
);
  logic [3:0] cnt;
  logic [3:0] bufs;
  // one done pulse per request, delayed to mimic a slow queue walk
  always @(posedge clk) begin
    if (!rst_n || !kill_valid) begin
      cnt <= '0;
      kill_done <= 1'b0;
    end else begin
      if (cnt <= DLY) cnt <= cnt + 4'h1;
      kill_done <= (cnt == DLY);
    end
  end
  // found flag only meaningful with done, otherwise shows its inverse
  assign kill_found = kill_done ? found : ~found;
  // buffers posted one at a time and consumed on take
  always @(posedge clk) begin
    if (!rst_n) bufs <= '0;
    else bufs <= bufs + {3'h0, post} - {3'h0, evq_take};
  end
  assign evq_buf_avail = (bufs != 4'h0);
  assign evq_buf_short = evq_buf_avail ? short : ~short;
endmodule // vsq_guest
`default_nettype wire

// ==== testbench.sv ====
// self-checking bench for the control and event queue engine
`timescale 1ns/10ps
`default_nettype none
`include "vsq_consts.vh"
module testbench;
  localparam logic [63:0] LUN_A = 64'h0000_0000_0000_0201;
  localparam logic [63:0] LUN_B = 64'h0000_0000_0003_0001;
  logic clk = 0, rst_n = 0, legacy_be = 0, hotplug_ok = 1, ctl_valid = 0;
  logic lu_evt_valid = 0, an_evt_valid = 0, found = 0, post = 0, short = 0;
  logic [31:0] ctl_type = '0, ctl_subtype = '0, ctl_evt_req = '0, an_evt_mask = 32'h16;
  logic [63:0] ctl_lun = '0, ctl_id = 64'hA5, lu_evt_lun = LUN_A, an_evt_lun = LUN_B;
  logic [1:0]  lu_evt_why = '0;
  wire logic ctl_busy, ctl_done, kill_valid, kill_done, kill_found, evq_buf_avail;
  wire logic evq_buf_short, evq_take, evq_write, sense_valid;
  wire logic [1:0] kill_scope;
  wire logic [3:0] sense_key;
  wire logic [7:0] ctl_resp, kill_resp, sense_asc, sense_ascq;
  wire logic [31:0] ctl_evt_act, evq_event, evq_reason;
  wire logic [63:0] kill_lun, kill_id, evq_lun, sense_lun;
  logic [7:0]  r_resp, k_resp, s_asc, s_ascq;
  logic [31:0] r_act, e_code, e_why;
  logic [63:0] k_id, e_lun, k_lun, s_lun;
  logic [3:0]  s_key;
  logic [1:0]  k_scope;
  logic        got_e;
  int          failures = 0, checks = 0;
  always #2.5 clk = ~clk;
  vsq_ctrl_event dut (.clk(clk), .rst_n(rst_n), .legacy_be(legacy_be), .hotplug_ok(hotplug_ok),
    .ctl_valid(ctl_valid), .ctl_type(ctl_type), .ctl_subtype(ctl_subtype), .ctl_lun(ctl_lun),
    .ctl_id(ctl_id), .ctl_evt_req(ctl_evt_req), .ctl_busy(ctl_busy), .ctl_done(ctl_done),
    .ctl_resp(ctl_resp), .ctl_evt_act(ctl_evt_act), .kill_valid(kill_valid),
    .kill_scope(kill_scope), .kill_lun(kill_lun), .kill_id(kill_id), .kill_resp(kill_resp),
    .kill_done(kill_done), .kill_found(kill_found), .evq_buf_avail(evq_buf_avail),
    .evq_buf_short(evq_buf_short), .evq_take(evq_take), .evq_write(evq_write),
    .evq_event(evq_event), .evq_lun(evq_lun), .evq_reason(evq_reason),
    .lu_evt_valid(lu_evt_valid), .lu_evt_why(lu_evt_why), .lu_evt_lun(lu_evt_lun),
    .an_evt_valid(an_evt_valid), .an_evt_mask(an_evt_mask), .an_evt_lun(an_evt_lun),
    .sense_valid(sense_valid), .sense_key(sense_key), .sense_asc(sense_asc),
    .sense_ascq(sense_ascq), .sense_lun(sense_lun));
  vsq_guest #(.DLY(3)) guest (.clk(clk), .rst_n(rst_n), .kill_valid(kill_valid), .found(found),
    .post(post), .short(short), .evq_take(evq_take), .kill_done(kill_done),
    .kill_found(kill_found), .evq_buf_avail(evq_buf_avail), .evq_buf_short(evq_buf_short));
  task automatic give_verdict;
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    checks++;
    if (got !== exp) begin
      failures++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic req(input logic [31:0] t, input logic [31:0] s, input logic [63:0] l,
                     input logic [31:0] e);
    int n;
    @(posedge clk);
    ctl_valid <= 1;
    ctl_type <= t;
    ctl_subtype <= s;
    ctl_lun <= l;
    ctl_evt_req <= e;
    @(posedge clk);
    ctl_valid <= 0;
    // the done pulse stands one cycle: look just after each edge, the take edge included
    #1;
    for (n = 0; n < 40 && !ctl_done; n++) begin
      if (kill_valid) {k_scope, k_resp, k_id, k_lun} = {kill_scope, kill_resp, kill_id, kill_lun};
      @(posedge clk);
      #1;
    end
    if (!ctl_done) begin
      failures++;
      $display("Error at %0t: control answer timed out", $time);
      give_verdict;
    end else begin
      {r_resp, r_act} = {ctl_resp, ctl_evt_act};
    end
  endtask
  task automatic watch;
    {got_e, e_code, e_lun, e_why, s_key, s_asc, s_ascq, s_lun} = 'x;
    got_e = 0;
    repeat (4) begin
      #1;
      if (evq_write) {got_e, e_code, e_lun, e_why} = {1'b1, evq_event, evq_lun, evq_reason};
      if (sense_valid) begin
        {s_key, s_asc, s_ascq} = {sense_key, sense_asc, sense_ascq};
        s_lun = sense_lun;
      end
      @(posedge clk);
    end
  endtask
  // buffer becomes visible at the same edge as the event, so both meet in one cycle
  task automatic pulse(input logic an, input logic [1:0] w, input logic bufd);
    @(posedge clk);
    post <= bufd;
    @(posedge clk);
    post <= 0;
    {an_evt_valid, lu_evt_valid, lu_evt_why} <= {an, !an, w};
    @(posedge clk);
    {an_evt_valid, lu_evt_valid} <= 2'b00;
    watch;
  endtask
  task automatic t_ctrl;
    req(`VSQ_TYPE_AN_QUERY, 0, LUN_A, 32'hFFFFFFFF);
    chk(r_resp, `VSQ_RESP_OK);
    chk(r_act, `VSQ_AN_CLASSES);
    req(`VSQ_TYPE_AN_QUERY, 0, 64'h02, 32'hFFFFFFFF);
    chk(r_resp, `VSQ_RESP_BAD_LUN);
    req(32'h5, 0, LUN_A, 0);
    chk(r_resp, `VSQ_RESP_FAILURE);
    @(posedge clk);
    legacy_be <= 1;
    req(32'h01000000, 0, LUN_A, 32'hFFFFFFFF);
    chk(r_act, 32'h7E000000);
    @(posedge clk);
    legacy_be <= 0;
  endtask
  task automatic t_tmf;
    logic [31:0] sub [7] = '{`VSQ_TMF_ABORT_TASK, `VSQ_TMF_ABORT_SET, `VSQ_TMF_IT_RESET,
                             `VSQ_TMF_LU_RESET, `VSQ_TMF_QUERY_TASK, `VSQ_TMF_QUERY_SET,
                             `VSQ_TMF_CLEAR_SET};
    logic [1:0]  scp [7] = '{2'd0, 2'd1, 2'd2, 2'd1, 2'd0, 2'd1, 2'd1};
    logic [7:0]  kr [7] = '{8'h02, 8'h02, 8'h04, 8'h04, 8'h00, 8'h00, 8'h02};
    logic [6:0]  fnd = 7'h30;
    for (int i = 0; i < 7; i++) begin
      found <= fnd[i];
      {k_scope, k_resp, k_id, k_lun} = 'x;
      req(`VSQ_TYPE_TMF, sub[i], LUN_B, 0);
      chk(k_scope, scp[i]);
      chk(k_lun, (sub[i] == `VSQ_TMF_IT_RESET) ? 64'h1 : LUN_B);
      chk(k_resp, kr[i]);
      chk(r_resp, fnd[i] ? `VSQ_FN_SUCCEEDED : `VSQ_FN_COMPLETE);
      if (i == 0) chk(k_id, 64'hA5);
    end
  endtask
  task automatic t_events;
    logic [19:0] sns [3] = '{20'h62900, 20'h63F0E, 20'h52500};
    req(`VSQ_TYPE_AN_SUB, 0, LUN_B, 32'h12);
    chk(r_act, 32'h12);
    pulse(1, 0, 1);
    chk({e_code, e_why}, {`VSQ_EVT_ASYNC, 32'h16 & 32'h12});
    for (int w = 0; w < 3; w++) begin
      pulse(0, w[1:0], 1);
      chk({e_code, e_why}, {`VSQ_EVT_RESET, w[31:0]});
      chk(e_lun, LUN_A);
      chk({s_key, s_asc, s_ascq}, sns[w]);
      chk(s_lun, LUN_A);
    end
    @(posedge clk);
    short <= 1;
    pulse(0, 0, 1);
    chk(e_code, `VSQ_EVT_NONE);
    short <= 0;
    pulse(0, 3, 1);
    chk(e_code, 32'h80000000);
    pulse(0, 0, 0);
    chk(got_e, 0);
    pulse(1, 0, 1);
    chk(e_code, 32'h80000002);
    hotplug_ok <= 0;
    pulse(0, 2, 1);
    chk(got_e, 0);
  endtask
  initial begin
    repeat (4) @(posedge clk);
    rst_n <= 1;
    t_ctrl;
    t_tmf;
    t_events;
    give_verdict;
  end
endmodule // testbench
bind vsq_ctrl_event vsq_chk u_chk (.clk(clk), .rst_n(rst_n), .legacy_be(legacy_be),
  .ctl_valid(ctl_valid), .ctl_type(ctl_type), .ctl_subtype(ctl_subtype), .ctl_lun(ctl_lun),
  .ctl_busy(ctl_busy), .ctl_done(ctl_done), .kill_valid(kill_valid), .kill_resp(kill_resp),
  .kill_done(kill_done), .lu_evt_valid(lu_evt_valid), .lu_evt_why(lu_evt_why),
  .sense_valid(sense_valid), .sense_key(sense_key), .sense_asc(sense_asc),
  .evq_buf_avail(evq_buf_avail), .evq_take(evq_take), .evq_write(evq_write),
  .evq_event(evq_event));
`default_nettype wire
